// >>> apw_chipset_model.sv
// Purpose: chipset and supply model at the far side of the button output
// Assumes: sleep input high means the system runs
// Notes: turns on when it sees the button low, off on command or in resume reset
`timescale 1ns/10ps
module apw_chipset_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic power_button_out_n,
	input wire logic resume_reset_out_n,
	input wire logic force_off,
	output logic sleep_state_in_n
);
	logic sys_on;

	// chipset held in resume reset cannot keep the system running
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sys_on <= 1'b0;
		else if (!resume_reset_out_n || force_off)
			sys_on <= 1'b0;
		else if (!power_button_out_n)
			sys_on <= 1'b1;
	end

	assign sleep_state_in_n = sys_on;
endmodule : apw_chipset_model

// >>> apw_pkg.sv
// Purpose: shared constants for the standby power and wake controller
// Assumes: 40 MHz pclk, register index n sits at byte address 4*n
// Notes: register indices, field positions, reset values, timing
package apw_pkg;
	localparam int unsigned PCLK_HZ = 40_000_000;
	// resume reset hold-off, least figure taken so it rounds up
	localparam int unsigned RSM_DELAY_MS = 100;
	localparam int unsigned RSM_DELAY_CYC = RSM_DELAY_MS * (PCLK_HZ / 1000);
	// wake pulse on the power button output
	localparam int unsigned WAKE_PULSE_US = 1000;
	localparam int unsigned WAKE_PULSE_CYC =
		WAKE_PULSE_US * (PCLK_HZ / 1_000_000);
	localparam int unsigned CNT_W = 23;
	localparam int unsigned PULSE_W = 16;
	localparam int unsigned ADDR_W = 10;

	// register indices
	localparam logic [7:0] IDX_WAKE_CTL = 8'he0;
	localparam logic [7:0] IDX_PW_INDEX = 8'he1;
	localparam logic [7:0] IDX_PW_DATA = 8'he2;
	localparam logic [7:0] IDX_LOSS_POL = 8'he4;
	localparam logic [7:0] IDX_MISC_CTL = 8'he6;
	localparam logic [7:0] IDX_STATUS = 8'he8;

	// wake control fields
	localparam int unsigned WC_KBD_EN = 6;
	localparam int unsigned WC_MOUSE_EN = 5;
	localparam int unsigned WC_BTN_SEL = 4;
	localparam int unsigned WC_CLICK_SEL = 1;
	localparam int unsigned WC_ANY_KEY = 0;
	// power loss policy field
	localparam int unsigned PL_POLICY_LSB = 5;
	localparam logic [1:0] POL_OFF = 2'h0;
	localparam logic [1:0] POL_ON = 2'h1;
	localparam logic [1:0] POL_PREV = 2'h2;
	localparam logic [1:0] POL_USER = 2'h3;
	// misc control fields
	localparam int unsigned MC_ANY_EVT = 7;
	localparam int unsigned MC_USER_PREV = 4;
	// status fields
	localparam int unsigned ST_PREV_ON = 0;
	localparam int unsigned ST_RSM_DONE = 1;
	localparam int unsigned ST_PULSE = 2;

	localparam logic [7:0] WAKE_CTL_RST = 8'h01;
	localparam logic [7:0] LOSS_POL_RST = 8'h00;
	localparam logic [7:0] MISC_CTL_RST = 8'h00;
	localparam logic [7:0] PW_INDEX_RST = 8'h00;

	// password stores: three of fifteen bytes
	localparam int unsigned PW_STORES = 3;
	localparam int unsigned PW_LEN = 15;
	localparam int unsigned PW_BYTES = PW_STORES * PW_LEN;
	localparam logic [3:0] PW_BANK0 = 4'h0;
	localparam logic [3:0] PW_BANK1 = 4'h3;
	localparam logic [3:0] PW_BANK2 = 4'h4;
	localparam logic [3:0] PW_LAST_LO = 4'he;
	localparam logic [7:0] BREAK_PREFIX = 8'hf0;
	typedef logic [PW_BYTES-1:0][7:0] apw_pw_t;

	typedef enum logic [3:0] {
		S_DOWN = 4'b0001,
		S_DELAY = 4'b0010,
		S_RESTORE = 4'b0100,
		S_RUN = 4'b1000
	} apw_state_t;
endpackage : apw_pkg

// >>> apw_top.sv
// Purpose: standby power sequencing, power loss restore, key/mouse wake
// Assumes: all inputs synchronous to pclk; supply detectors are inputs
// Notes: APB slave, one wait state on every access while clk_en stays high
`timescale 1ns/10ps

// What this block does
// - button output follows low button input
// - policy 00 leaves system off
// - policy 01 always turns system on
// - policy 10 restores recorded prior state
// - main supply drop records sleep input
// - policy 11 uses software state bit
// - enabled wake event pulses button low
// - keyboard wake only when enabled
// - any key or password match wakes
// - three indexed password stores via data
// - key is make, F0, make
// - mouse wake only when enabled
// - any-event mode: any or one click
// - specific button, one or two clicks
// - delay then release resume reset
// - standby loss drops resume reset
// - resume delay between 100 and 200 ms
module apw_top #(
	parameter logic [apw_pkg::CNT_W-1:0] RSM_CYCLES =
		apw_pkg::CNT_W'(apw_pkg::RSM_DELAY_CYC),
	parameter logic [apw_pkg::PULSE_W-1:0] WAKE_CYCLES =
		apw_pkg::PULSE_W'(apw_pkg::WAKE_PULSE_CYC)
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [apw_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic power_button_in_n,
	output logic power_button_out_n,
	input wire logic sleep_state_in_n,
	output logic supply_on_out_n,
	output logic resume_reset_out_n,
	input wire logic standby_supply_valid,
	input wire logic standby_supply_low,
	input wire logic main_supply_low,
	input wire logic kbd_valid,
	input wire logic [7:0] kbd_byte,
	input wire logic mouse_valid,
	input wire logic mouse_left,
	input wire logic mouse_right,
	input wire logic mouse_moved
);
	typedef struct packed {
		apw_pkg::apw_state_t st;
		logic [apw_pkg::CNT_W-1:0] dly;
		logic [apw_pkg::PULSE_W-1:0] pulse;
		logic pulsing;
		logic prev_on;
		logic main_low_q;
		logic second_click;
		logic [apw_pkg::PW_STORES-1:0][3:0] pos;
		apw_pkg::apw_pw_t pw;
		logic [7:0] wake_ctl;
		logic [7:0] pw_index;
		logic [7:0] loss_pol;
		logic [7:0] misc_ctl;
		logic ack;
		logic [31:0] rdata;
		logic supply_n;
	} apw_regs_t;

	apw_regs_t s;
	apw_regs_t next_s;

	// {valid, slot}: maps a password index onto the flat byte array
	function automatic logic [6:0] pw_slot(input logic [7:0] idx);
		logic [1:0] bank;
		logic ok;
		bank = 2'h0;
		ok = idx[3:0] <= apw_pkg::PW_LAST_LO;
		case (idx[7:4])
			apw_pkg::PW_BANK0: bank = 2'h0;
			apw_pkg::PW_BANK1: bank = 2'h1;
			apw_pkg::PW_BANK2: bank = 2'h2;
			default: ok = 1'b0;
		endcase
		return {ok, 6'(bank * apw_pkg::PW_LEN + idx[3:0])};
	endfunction : pw_slot

	function automatic logic [7:0] pw_at(input apw_pkg::apw_pw_t a,
		input int unsigned i);
		if (i < apw_pkg::PW_BYTES) begin
			return a[i];
		end
		return 8'h00;
	endfunction : pw_at

	function automatic logic restore_on(input logic [1:0] pol,
		input logic prev_on, input logic user_off);
		case (pol)
			apw_pkg::POL_OFF: return 1'b0;
			apw_pkg::POL_ON: return 1'b1;
			apw_pkg::POL_PREV: return prev_on;
			apw_pkg::POL_USER: return ~user_off;
			default: return 1'b0;
		endcase
	endfunction : restore_on

	logic [7:0] idx;
	logic hit;
	logic wr;
	logic [6:0] slot;
	logic kbd_wake;
	logic mouse_wake;
	logic sys_off;
	logic [7:0] rd_val;

	assign idx = paddr[apw_pkg::ADDR_W-1:2];
	assign slot = pw_slot(s.pw_index);
	assign hit = idx == apw_pkg::IDX_WAKE_CTL ||
		idx == apw_pkg::IDX_PW_INDEX || idx == apw_pkg::IDX_PW_DATA ||
		idx == apw_pkg::IDX_LOSS_POL || idx == apw_pkg::IDX_MISC_CTL ||
		idx == apw_pkg::IDX_STATUS;
	assign wr = psel && penable && s.ack && pwrite && hit;
	// wake only while the system sleeps, else a key press would power off
	assign sys_off = ~sleep_state_in_n;

	// APB: one wait state; pready gated by clk_en so writes never get lost
	assign pready = psel && penable && s.ack && clk_en;
	assign pslverr = pready && !hit;
	assign prdata = s.rdata;

	always_comb begin
		rd_val = 8'h00;
		case (idx)
			apw_pkg::IDX_WAKE_CTL: rd_val = s.wake_ctl;
			apw_pkg::IDX_PW_INDEX: rd_val = s.pw_index;
			apw_pkg::IDX_PW_DATA: begin
				if (slot[6]) begin
					rd_val = pw_at(s.pw, int'(slot[5:0]));
				end
			end
			apw_pkg::IDX_LOSS_POL: rd_val = s.loss_pol;
			apw_pkg::IDX_MISC_CTL: rd_val = s.misc_ctl;
			apw_pkg::IDX_STATUS: begin
				rd_val[apw_pkg::ST_PREV_ON] = s.prev_on;
				rd_val[apw_pkg::ST_RSM_DONE] = s.st == apw_pkg::S_RUN;
				rd_val[apw_pkg::ST_PULSE] = s.pulsing;
			end
			default: rd_val = 8'h00;
		endcase
	end

	// password matcher: each store advances on an equal byte; a zero byte
	// or the store end completes it, so trailing zeros must be written
	always_comb begin
		logic [7:0] cur;
		logic [7:0] first;
		logic [7:0] nxt;
		logic [3:0] np;
		int unsigned base;
		kbd_wake = 1'b0;
		cur = 8'h00;
		first = 8'h00;
		nxt = 8'h00;
		np = 4'h0;
		base = 0;
		next_s = s;
		for (int k = 0; k < apw_pkg::PW_STORES; k++) begin
			base = k * apw_pkg::PW_LEN;
			cur = pw_at(s.pw, base + int'(s.pos[k]));
			first = pw_at(s.pw, base);
			if (kbd_valid) begin
				// make, break prefix, make all compared alike
				if (kbd_byte == cur && cur != 8'h00) begin
					np = s.pos[k] + 4'h1;
					nxt = pw_at(s.pw, base + int'(np));
					if (np == 4'(apw_pkg::PW_LEN) || nxt == 8'h00) begin
						kbd_wake = 1'b1;
						np = 4'h0;
					end
				end else if (kbd_byte == first && first != 8'h00) begin
					np = 4'h1;
				end else begin
					np = 4'h0;
				end
				next_s.pos[k] = np;
			end
		end
		if (s.wake_ctl[apw_pkg::WC_ANY_KEY]) begin
			kbd_wake = kbd_valid && kbd_byte != apw_pkg::BREAK_PREFIX;
		end
		kbd_wake = kbd_wake && s.wake_ctl[apw_pkg::WC_KBD_EN];

		// mouse event decode
		mouse_wake = 1'b0;
		if (mouse_valid) begin
			if (s.misc_ctl[apw_pkg::MC_ANY_EVT]) begin
				mouse_wake = mouse_left || mouse_right ||
					(mouse_moved && s.wake_ctl[apw_pkg::WC_CLICK_SEL]);
			end else if ((s.wake_ctl[apw_pkg::WC_BTN_SEL] ? mouse_right :
				mouse_left)) begin
				if (s.wake_ctl[apw_pkg::WC_CLICK_SEL]) begin
					mouse_wake = 1'b1;
				end else begin
					mouse_wake = s.second_click;
					next_s.second_click = ~s.second_click;
				end
			end else if (mouse_left || mouse_right) begin
				// other button breaks a double click in progress
				next_s.second_click = 1'b0;
			end
		end
		mouse_wake = mouse_wake && s.wake_ctl[apw_pkg::WC_MOUSE_EN];

		// register writes
		if (wr) begin
			case (idx)
				apw_pkg::IDX_WAKE_CTL: next_s.wake_ctl = pwdata[7:0];
				apw_pkg::IDX_PW_INDEX: next_s.pw_index = pwdata[7:0];
				apw_pkg::IDX_PW_DATA: begin
					if (slot[6]) begin
						next_s.pw[slot[5:0]] = pwdata[7:0];
					end
				end
				apw_pkg::IDX_LOSS_POL: next_s.loss_pol = pwdata[7:0];
				apw_pkg::IDX_MISC_CTL: next_s.misc_ctl = pwdata[7:0];
				default: next_s.wake_ctl = s.wake_ctl;
			endcase
		end
		if (psel && penable && !s.ack) begin
			next_s.rdata = {24'h000000, rd_val};
		end
		next_s.ack = psel && penable && !s.ack;

		// previous state caught on the main supply's falling edge
		next_s.main_low_q = main_supply_low;
		if (main_supply_low && !s.main_low_q) begin
			next_s.prev_on = sleep_state_in_n;
		end
		next_s.supply_n = ~sleep_state_in_n;

		// wake pulse timer
		if (s.pulsing) begin
			if (s.pulse == WAKE_CYCLES - 1'b1) begin
				next_s.pulsing = 1'b0;
				next_s.pulse = '0;
			end else begin
				next_s.pulse = s.pulse + 1'b1;
			end
		end

		// standby sequencer
		case (s.st)
			apw_pkg::S_DOWN: begin
				next_s.dly = '0;
				if (standby_supply_valid) begin
					next_s.st = apw_pkg::S_DELAY;
				end
			end
			apw_pkg::S_DELAY: begin
				if (s.dly == RSM_CYCLES - 1'b1) begin
					next_s.st = apw_pkg::S_RESTORE;
				end else begin
					next_s.dly = s.dly + 1'b1;
				end
			end
			apw_pkg::S_RESTORE: begin
				next_s.st = apw_pkg::S_RUN;
				if (restore_on(s.loss_pol[apw_pkg::PL_POLICY_LSB +: 2],
					s.prev_on, s.misc_ctl[apw_pkg::MC_USER_PREV])) begin
					next_s.pulsing = 1'b1;
					next_s.pulse = '0;
				end
			end
			apw_pkg::S_RUN: begin
				if ((kbd_wake || mouse_wake) && sys_off && !s.pulsing) begin
					next_s.pulsing = 1'b1;
					next_s.pulse = '0;
				end
			end
			default: next_s.st = apw_pkg::S_DOWN;
		endcase
		// standby loss overrides the sequencer and wake pulse and restarts the delay
		if (standby_supply_low) begin
			next_s.st = apw_pkg::S_DOWN;
			next_s.dly = '0;
			next_s.pulsing = 1'b0;
			next_s.pulse = '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '{st: apw_pkg::S_DOWN, dly: '0, pulse: '0,
				pulsing: 1'b0, prev_on: 1'b0, main_low_q: 1'b0,
				second_click: 1'b0, pos: '0, pw: '0,
				wake_ctl: apw_pkg::WAKE_CTL_RST,
				pw_index: apw_pkg::PW_INDEX_RST,
				loss_pol: apw_pkg::LOSS_POL_RST,
				misc_ctl: apw_pkg::MISC_CTL_RST,
				ack: 1'b0, rdata: '0, supply_n: 1'b1};
		end else if (clk_en) begin
			s <= next_s;
		end
	end

	// pin outputs: button and resume reset combinational so the pass-through adds no lag; supply on is registered
	assign power_button_out_n = power_button_in_n && !s.pulsing;
	assign resume_reset_out_n = s.st == apw_pkg::S_RUN &&
		!standby_supply_low;
	assign supply_on_out_n = s.supply_n;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	pass_through_a: assert property (
		!power_button_in_n |-> !power_button_out_n)
		else $error("button not passed");
	prev_record_a: assert property (
		clk_en && main_supply_low && !s.main_low_q
		|=> s.prev_on == $past(sleep_state_in_n))
		else $error("previous state not caught");
	rsm_drop_a: assert property (
		standby_supply_low |-> !resume_reset_out_n)
		else $error("resume reset held");
	rsm_delay_a: assert property (
		$rose(resume_reset_out_n) |->
		$past(s.dly) == RSM_CYCLES - 1'b1 || $past(standby_supply_low))
		else $error("resume reset early");
	supply_on_a: assert property (
		clk_en |=> supply_on_out_n == !$past(sleep_state_in_n))
		else $error("supply on wrong");
	policy_off_a: assert property (
		s.st == apw_pkg::S_RESTORE && clk_en && !standby_supply_low &&
		s.loss_pol[apw_pkg::PL_POLICY_LSB +: 2] == apw_pkg::POL_OFF &&
		!s.pulsing |=> !s.pulsing)
		else $error("policy off woke");
	policy_on_a: assert property (
		s.st == apw_pkg::S_RESTORE && clk_en && !standby_supply_low &&
		s.loss_pol[apw_pkg::PL_POLICY_LSB +: 2] == apw_pkg::POL_ON
		|=> s.pulsing ##1 !power_button_out_n)
		else $error("policy on idle");
	policy_prev_a: assert property (
		s.st == apw_pkg::S_RESTORE && clk_en && !standby_supply_low &&
		s.loss_pol[apw_pkg::PL_POLICY_LSB +: 2] == apw_pkg::POL_PREV &&
		!s.pulsing |=> s.pulsing == $past(s.prev_on))
		else $error("policy previous wrong");
	policy_user_a: assert property (
		s.st == apw_pkg::S_RESTORE && clk_en && !standby_supply_low &&
		s.loss_pol[apw_pkg::PL_POLICY_LSB +: 2] == apw_pkg::POL_USER &&
		!s.pulsing
		|=> s.pulsing == !$past(s.misc_ctl[apw_pkg::MC_USER_PREV]))
		else $error("policy user wrong");
	kbd_gate_a: assert property (
		!s.wake_ctl[apw_pkg::WC_KBD_EN] |-> !kbd_wake)
		else $error("keyboard wake while off");
	mouse_gate_a: assert property (
		!s.wake_ctl[apw_pkg::WC_MOUSE_EN] |-> !mouse_wake)
		else $error("mouse wake while off");
	pulse_len_a: assert property (
		s.pulsing |-> s.pulse < WAKE_CYCLES)
		else $error("wake pulse too long");
	pulse_end_a: assert property (
		$fell(s.pulsing) && !$past(standby_supply_low) |->
		$past(s.pulse) == WAKE_CYCLES - 1'b1)
		else $error("wake pulse cut short");
	wake_go_a: assert property (
		s.st == apw_pkg::S_RUN && clk_en && kbd_wake && sys_off &&
		!s.pulsing && !standby_supply_low |=> !power_button_out_n)
		else $error("wake not issued");
	any_key_a: assert property (
		s.st == apw_pkg::S_RUN && clk_en && sys_off && !s.pulsing &&
		!standby_supply_low && kbd_valid &&
		kbd_byte != apw_pkg::BREAK_PREFIX &&
		s.wake_ctl[apw_pkg::WC_KBD_EN] &&
		s.wake_ctl[apw_pkg::WC_ANY_KEY]
		|=> s.pulsing)
		else $error("any key did not wake");
	mouse_any_a: assert property (
		s.st == apw_pkg::S_RUN && clk_en && sys_off && !s.pulsing &&
		!standby_supply_low && mouse_valid && mouse_moved &&
		s.misc_ctl[apw_pkg::MC_ANY_EVT] &&
		s.wake_ctl[apw_pkg::WC_MOUSE_EN] &&
		s.wake_ctl[apw_pkg::WC_CLICK_SEL]
		|=> s.pulsing)
		else $error("mouse movement did not wake");
endmodule : apw_top

// >>> tb_top.sv
// Purpose: self-checking bench for the standby power and wake controller
// Assumes: short resume and wake counts; chipset model on the far side
// Notes: APB master waits on pready; watchdog ends a hang
`timescale 1ns/10ps
module tb_top;
	localparam int RSM = 20;
	localparam int WK = 8;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [9:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic power_button_in_n, power_button_out_n, sleep_state_in_n;
	logic supply_on_out_n, resume_reset_out_n, rerr, force_off, clk_en;
	logic standby_supply_valid, standby_supply_low, main_supply_low;
	logic kbd_valid, mouse_valid, mouse_left, mouse_right, mouse_moved;
	logic [7:0] kbd_byte;
	int err_total = 0;
	int n_checks = 0;
	// mouse cases: control word, events {left,right,moved}
	logic [7:0] m_wc [9] = '{8'h03, 8'h23, 8'h21, 8'h21, 8'h23, 8'h23,
		8'h31, 8'h31, 8'h31};
	logic [2:0] m_ev [9] = '{3'h1, 3'h1, 3'h2, 3'h1, 3'h2, 3'h4, 3'h4,
		3'h2, 3'h2};
	logic [8:0] m_any = 9'h00f;
	logic [8:0] m_exp = 9'h126;
	logic [1:0] p_pol [6] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
	logic [5:0] p_prev = 6'h25;
	logic [5:0] p_exp = 6'h16;

	apw_top #(.RSM_CYCLES(23'd20), .WAKE_CYCLES(16'd8)) DUT (
		.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .power_button_in_n(power_button_in_n),
		.power_button_out_n(power_button_out_n),
		.sleep_state_in_n(sleep_state_in_n),
		.supply_on_out_n(supply_on_out_n),
		.resume_reset_out_n(resume_reset_out_n),
		.standby_supply_valid(standby_supply_valid),
		.standby_supply_low(standby_supply_low),
		.main_supply_low(main_supply_low), .kbd_valid(kbd_valid),
		.kbd_byte(kbd_byte), .mouse_valid(mouse_valid),
		.mouse_left(mouse_left), .mouse_right(mouse_right),
		.mouse_moved(mouse_moved));

	apw_chipset_model chipset (.pclk(pclk), .presetn(presetn),
		.power_button_out_n(power_button_out_n),
		.resume_reset_out_n(resume_reset_out_n), .force_off(force_off),
		.sleep_state_in_n(sleep_state_in_n));

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	task summarize;
		if (err_total == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize

	task chk_v(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_v

	task chk_n(input int got, input int exp);
		n_checks++;
		if (got != exp) begin
			err_total++;
			$display("Error at %0t: count %0d expected %0d", $time, got, exp);
		end
	endtask : chk_n

	task apb(input logic [7:0] idx, input logic w, input logic [7:0] wd);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		// read before this edge's updates land: the values it samples
		rdat = prdata;
		rerr = pslverr;
		if (pready !== 1'b1) begin
			err_total++;
			$display("Error at %0t: no pready", $time);
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [7:0] idx, input logic [7:0] d);
		apb(idx, 1'b1, d);
	endtask : wr

	task rd(input logic [7:0] idx, input logic [31:0] exp, input logic e);
		apb(idx, 1'b0, 8'h00);
		chk_v(rdat, exp);
		chk_v(32'(rerr), 32'(e));
	endtask : rd

	task wait_pulse(input logic exp_on);
		int k;
		int n;
		k = 0;
		n = 0;
		while (power_button_out_n !== 1'b0 && k < 12) begin
			@(negedge pclk);
			k++;
		end
		while (power_button_out_n === 1'b0 && n < 50) begin
			n++;
			@(negedge pclk);
		end
		chk_n(n, exp_on ? WK : 0);
	endtask : wait_pulse

	task set_state(input logic on);
		@(posedge pclk);
		force_off <= 1'b1;
		@(posedge pclk);
		force_off <= 1'b0;
		if (on) begin
			power_button_in_n <= 1'b0;
			repeat (3) begin
				@(negedge pclk);
				chk_v(32'(power_button_out_n), 32'h0);
			end
			@(posedge pclk);
			power_button_in_n <= 1'b1;
		end
		repeat (3) @(negedge pclk);
		chk_v(32'(supply_on_out_n), 32'(!on));
		chk_v(32'(power_button_out_n), 32'h1);
	endtask : set_state

	task bring_up(input logic exp_on);
		int n;
		n = 0;
		@(posedge pclk);
		standby_supply_low <= 1'b0;
		standby_supply_valid <= 1'b1;
		main_supply_low <= 1'b0;
		do begin
			@(negedge pclk);
			n++;
		end while (resume_reset_out_n !== 1'b1 && n < 200);
		chk_n(n, RSM + 3);
		wait_pulse(exp_on);
		chk_v(32'(sleep_state_in_n), 32'(exp_on));
	endtask : bring_up

	task power_cycle(input int i);
		set_state(p_prev[i]);
		wr(8'he4, {1'b0, p_pol[i], 5'h00});
		wr(8'he6, i == 5 ? 8'h10 : 8'h00);
		@(posedge pclk);
		main_supply_low <= 1'b1;
		repeat (2) @(posedge pclk);
		apb(8'he8, 1'b0, 8'h00);
		chk_v(32'(rdat[0]), 32'(p_prev[i]));
		@(posedge pclk);
		standby_supply_low <= 1'b1;
		standby_supply_valid <= 1'b0;
		@(negedge pclk);
		chk_v(32'(resume_reset_out_n), 32'h0);
		repeat (3) @(posedge pclk);
		bring_up(p_exp[i]);
	endtask : power_cycle

	task send_key(input logic [7:0] b);
		@(posedge pclk);
		kbd_valid <= 1'b1;
		kbd_byte <= b;
		@(posedge pclk);
		kbd_valid <= 1'b0;
		@(negedge pclk);
	endtask : send_key

	task mouse_ev(input logic [2:0] ev);
		@(posedge pclk);
		mouse_valid <= 1'b1;
		{mouse_left, mouse_right, mouse_moved} <= ev;
		@(posedge pclk);
		mouse_valid <= 1'b0;
		@(negedge pclk);
	endtask : mouse_ev

	initial begin
		#1_000_000;
		err_total++;
		$display("Error at %0t: watchdog expired", $time);
		summarize();
	end

	initial begin
		{presetn, psel, penable, pwrite, force_off} = '0;
		{kbd_valid, mouse_valid, mouse_left, mouse_right} = '0;
		{mouse_moved, standby_supply_valid, standby_supply_low} = '0;
		main_supply_low = 1'b0;
		clk_en = 1'b1;
		power_button_in_n = 1'b1;
		paddr = '0;
		pwdata = '0;
		kbd_byte = '0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rd(8'he0, 32'h01, 1'b0);
		rd(8'he4, 32'h00, 1'b0);
		rd(8'he6, 32'h00, 1'b0);
		rd(8'he3, 32'h00, 1'b1);
		// frozen clock enable must stall the answer, not lose it
		fork
			rd(8'he0, 32'h01, 1'b0);
			begin
				@(posedge pclk);
				clk_en <= 1'b0;
				repeat (3) @(posedge pclk);
				clk_en <= 1'b1;
			end
		join
		bring_up(1'b0);
		set_state(1'b1);
		set_state(1'b0);
		send_key(8'h1c);
		wait_pulse(1'b0);
		wr(8'he0, 8'h41);
		send_key(8'h1c);
		wait_pulse(1'b1);
		set_state(1'b0);
		wr(8'he0, 8'h40);
		for (int i = 0; i < 15; i++) begin
			wr(8'he1, 8'(i));
			wr(8'he2, i == 1 ? 8'hf0 : (i < 3 ? 8'h45 : 8'h00));
		end
		wr(8'he1, 8'h30);
		wr(8'he2, 8'h5a);
		wr(8'he1, 8'h01);
		rd(8'he2, 32'hf0, 1'b0);
		wr(8'he1, 8'h30);
		rd(8'he2, 32'h5a, 1'b0);
		wr(8'he2, 8'h00);
		send_key(8'h16);
		wait_pulse(1'b0);
		send_key(8'h45);
		send_key(8'hf0);
		send_key(8'h45);
		wait_pulse(1'b1);
		for (int i = 0; i < 9; i++) begin
			set_state(1'b0);
			wr(8'he0, m_wc[i]);
			wr(8'he6, m_any[i] ? 8'h80 : 8'h00);
			mouse_ev(m_ev[i]);
			wait_pulse(m_exp[i]);
		end
		wr(8'he0, 8'h01);
		for (int i = 0; i < 6; i++)
			power_cycle(i);
		summarize();
	end
endmodule : tb_top
